// ==== verilog/msr_readback_regs.sv ====
// Motor status readback registers with sticky faults and measurements on APB.
//
// Overview of operation
// (RL1) Fault bits 5 to 0 flag closed-loop stuck, open-loop stuck, no motor, abnormal emf constant, abnormal speed and hardware current limit, each sticky, zero at reset and cleared by writing one.
// (RL2) The speed register holds a 16-bit unsigned value whose tenth is the speed in hertz.
// (RL3) The period register holds a 16-bit value whose tenfold is the period in microseconds.
// (RL4) The emf constant register holds a 16-bit value that divided by 2 and by 1090 gives volts per hertz.
// (RL5) The current register holds an 11-bit offset-coded field in bits 10 to 0 giving 3 times field minus 1023 over 2048 amperes.
// (RL6) Current register bits 15 to 11 read as zero and software leaves them alone.
// (RL7) Fault bit 15 sets on over-temperature shutdown and clears by writing one.
// (RL8) Writes to the four measurement registers are ignored and each reads zero after reset until updated.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "msr_defs.svh"

module msr_readback_regs
  import msr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CUR_W = `MSR_CUR_W
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fault events
  input wire logic closed_loop_stuck_det,
  input wire logic open_loop_stuck_det,
  input wire logic no_motor_det,
  input wire logic emf_constant_abnormal_det,
  input wire logic speed_abnormal_det,
  input wire logic hw_current_limit_det,
  input wire logic over_temperature_det,
  // Measurements
  input wire logic speed_valid,
  input wire logic [15:0] speed_value,
  input wire logic period_valid,
  input wire logic [15:0] period_value,
  input wire logic backemf_valid,
  input wire logic [15:0] backemf_value,
  input wire logic current_valid,
  input wire logic [CUR_W-1:0] current_value,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic [`MSR_IDX_W-1:0] idx;
  msr_sel_t sel;
  logic setup_phase;
  logic access_done;
  logic wr_done;

  assign idx = paddr[`MSR_IDX_W+1:2];
  assign sel = msr_decode(idx);
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done = access_done && pwrite;

  // ==========================================================================
  // Fault flags
  // ==========================================================================
  logic [`MSR_NUM_FLAGS-1:0] fault_set;
  logic [`MSR_NUM_FLAGS-1:0] fault_clr;
  logic [`MSR_NUM_FLAGS-1:0] fault_q;
  msr_word_t fault_word;
  logic wr_fault;

  assign wr_fault = wr_done && (sel == msr_sel_fault);

  assign fault_set = {
    over_temperature_det,
    closed_loop_stuck_det,
    open_loop_stuck_det,
    no_motor_det,
    emf_constant_abnormal_det,
    speed_abnormal_det,
    hw_current_limit_det
  };

  assign fault_clr = {
    pwdata[`MSR_BIT_OVER_TEMP],
    pwdata[`MSR_BIT_CLOSED_LOOP_STUCK:`MSR_BIT_HW_CURRENT_LIMIT]
  } & {`MSR_NUM_FLAGS{wr_fault}}; // see (RL1) see (RL7)

  msr_sticky_flags #(
    .N(`MSR_NUM_FLAGS)
  ) u_flags (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .set_in(fault_set),
    .clr_in(fault_clr),
    .flags(fault_q)
  );

  assign fault_word = {fault_q[6], 9'h000, fault_q[5:0]}; // see (RL1) see (RL7)

  // ==========================================================================
  // Measurement registers
  // ==========================================================================
  msr_word_t speed_q;
  msr_word_t period_q;
  msr_word_t bemf_q;
  logic [CUR_W-1:0] current_q;

  msr_meas_capture #(
    .W(16)
  ) u_speed (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .valid(speed_valid),
    .value(speed_value),
    .reading(speed_q)
  );

  msr_meas_capture #(
    .W(16)
  ) u_period (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .valid(period_valid),
    .value(period_value),
    .reading(period_q)
  );

  msr_meas_capture #(
    .W(16)
  ) u_bemf (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .valid(backemf_valid),
    .value(backemf_value),
    .reading(bemf_q)
  );

  msr_meas_capture #(
    .W(CUR_W)
  ) u_current (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .valid(current_valid),
    .value(current_value),
    .reading(current_q)
  );

  // ==========================================================================
  // Interrupt mask
  // ==========================================================================
  msr_word_t mask_reg;
  logic irq_reg;
  logic irq_next;

  assign irq_next = |(fault_word & mask_reg);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= `MSR_MASK_RESET;
    end else if (ce && wr_done && (sel == msr_sel_mask)) begin
      mask_reg <= pwdata[15:0] & `MSR_FAULT_IMPL;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

  // ==========================================================================
  // Read data and answer
  // ==========================================================================
  msr_word_t rd_word;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  always_comb begin
    rd_word = 16'h0000;
    case (sel)
      msr_sel_fault: rd_word = fault_word;
      msr_sel_speed: rd_word = speed_q; // see (RL2)
      msr_sel_period: rd_word = period_q; // see (RL3)
      msr_sel_bemf: rd_word = bemf_q; // see (RL4)
      msr_sel_current: rd_word = {{(16-CUR_W){1'b0}}, current_q}; // see (RL5) see (RL6)
      msr_sel_mask: rd_word = mask_reg;
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= `MSR_RDATA_RESET;
    end else if (ce && setup_phase && !pwrite) begin
      prdata_reg <= {16'h0000, rd_word};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      if (setup_phase) begin
        pready_reg <= 1'b1;
        pslverr_reg <= (sel == msr_sel_none);
      end else if (access_done) begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence setup_s;
    ce && psel && !penable;
  endsequence

  sequence read_setup_s(msr_sel_t s);
    ce && psel && !penable && !pwrite && (sel == s);
  endsequence

  sequence write_done_s(msr_sel_t s);
    ce && psel && penable && pready && pwrite && (sel == s);
  endsequence

  ready_after_setup_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    setup_s |=> pready_reg)
    else $error("Ready did not follow the setup cycle.");

  speed_read_a: assert property ( // see (RL2)
    @(posedge clk) disable iff (!rst_b)
    read_setup_s(msr_sel_speed) |=> prdata_reg == {16'h0000, $past(speed_q)})
    else $error("Speed read returned a wrong value.");

  current_upper_zero_a: assert property ( // see (RL6)
    @(posedge clk) disable iff (!rst_b)
    read_setup_s(msr_sel_current) |=> prdata_reg[31:11] == 21'h00_0000)
    else $error("Current read showed reserved bits set.");

  current_read_a: assert property ( // see (RL5)
    @(posedge clk) disable iff (!rst_b)
    read_setup_s(msr_sel_current) |=> prdata_reg[10:0] == $past(current_q))
    else $error("Current read returned a wrong field.");

  period_read_a: assert property ( // see (RL3)
    @(posedge clk) disable iff (!rst_b)
    read_setup_s(msr_sel_period) |=> prdata_reg == {16'h0000, $past(period_q)})
    else $error("Period read returned a wrong value.");

  bemf_read_a: assert property ( // see (RL4)
    @(posedge clk) disable iff (!rst_b)
    read_setup_s(msr_sel_bemf) |=> prdata_reg == {16'h0000, $past(bemf_q)})
    else $error("Emf constant read returned a wrong value.");

  speed_write_ignored_a: assert property ( // see (RL8)
    @(posedge clk) disable iff (!rst_b)
    write_done_s(msr_sel_speed) ##0 !speed_valid |=> $stable(speed_q))
    else $error("Write altered the speed register.");

  over_temp_clear_a: assert property ( // see (RL7)
    @(posedge clk) disable iff (!rst_b)
    write_done_s(msr_sel_fault) ##0 (pwdata[15] && !over_temperature_det)
      |=> !fault_word[15])
    else $error("Over-temperature flag did not clear.");

  lock_event_a: assert property ( // see (RL1)
    @(posedge clk) disable iff (!rst_b)
    ce && closed_loop_stuck_det |=> fault_word[5] ##1 (fault_word[5] || $past(wr_fault)))
    else $error("Closed-loop stuck flag did not hold.");

  irq_level_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce |=> irq_reg == $past(irq_next))
    else $error("Interrupt does not follow masked faults.");

  unmapped_error_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    setup_s and (sel == msr_sel_none) |=> pready_reg && pslverr_reg)
    else $error("Unmapped access did not raise an error.");

endmodule

`default_nettype wire

// ==== verilog/msr_defs.svh ====
// Register offsets, field positions and reset values of the motor status readback block.
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define MSR_IDX_W 10
`define MSR_IDX_FAULT 10'h000
`define MSR_IDX_SPEED 10'h001
`define MSR_IDX_PERIOD 10'h002
`define MSR_IDX_BEMF 10'h003
`define MSR_IDX_CURRENT 10'h004
`define MSR_IDX_MASK 10'h010

// ==========================================================================
// Field positions
// ==========================================================================
`define MSR_BIT_OVER_TEMP 15
`define MSR_BIT_CLOSED_LOOP_STUCK 5
`define MSR_BIT_OPEN_LOOP_STUCK 4
`define MSR_BIT_NO_MOTOR 3
`define MSR_BIT_EMF_ABNORMAL 2
`define MSR_BIT_SPEED_ABNORMAL 1
`define MSR_BIT_HW_CURRENT_LIMIT 0
`define MSR_NUM_FLAGS 7
`define MSR_CUR_W 11

// ==========================================================================
// Reset values and implemented bits
// ==========================================================================
`define MSR_FAULT_IMPL 16'h803f
`define MSR_FAULT_RESET 16'h0000
`define MSR_MASK_RESET 16'h0000
`define MSR_MEAS_RESET 16'h0000
`define MSR_RDATA_RESET 32'h0000_0000

`endif

// ==== verilog/msr_pkg.sv ====
// Types and the register decoder of the motor status readback block.
`default_nettype none
`include "msr_defs.svh"

package msr_pkg;

  typedef logic [15:0] msr_word_t;

  typedef enum logic [2:0] {
    msr_sel_fault,
    msr_sel_speed,
    msr_sel_period,
    msr_sel_bemf,
    msr_sel_current,
    msr_sel_mask,
    msr_sel_none
  } msr_sel_t;

  function automatic msr_sel_t msr_decode(input logic [`MSR_IDX_W-1:0] idx);
    msr_sel_t sel;
    sel = msr_sel_none;
    case (idx)
      `MSR_IDX_FAULT: sel = msr_sel_fault;
      `MSR_IDX_SPEED: sel = msr_sel_speed;
      `MSR_IDX_PERIOD: sel = msr_sel_period;
      `MSR_IDX_BEMF: sel = msr_sel_bemf;
      `MSR_IDX_CURRENT: sel = msr_sel_current;
      `MSR_IDX_MASK: sel = msr_sel_mask;
      default: sel = msr_sel_none;
    endcase
    return sel;
  endfunction

endpackage

`default_nettype wire

// ==== verilog/msr_sticky_flags.sv ====
// Sticky fault flags that set on an event and clear on a written one.
`timescale 1ns/1ns
`default_nettype none

module msr_sticky_flags #(
  parameter int N = 7
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Events and clears
  input wire logic [N-1:0] set_in,
  input wire logic [N-1:0] clr_in,
  // Flags
  output logic [N-1:0] flags
);

  logic [N-1:0] flag_reg;

  assign flags = flag_reg;

  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        flag_reg[i] <= 1'b0;
      end else if (ce) begin
        if (set_in[i]) begin
          flag_reg[i] <= 1'b1; // see (RL1) see (RL7)
        end else if (clr_in[i]) begin
          flag_reg[i] <= 1'b0; // see (RL1) see (RL7)
        end
      end
    end

    flag_set_wins_a: assert property ( // see (RL1)
      @(posedge clk) disable iff (!rst_b)
      ce && set_in[i] |=> flag_reg[i])
      else $error("Flag did not set on its event.");

    flag_clear_a: assert property ( // see (RL7)
      @(posedge clk) disable iff (!rst_b)
      ce && clr_in[i] && !set_in[i] |=> !flag_reg[i])
      else $error("Flag did not clear on a written one.");

    flag_sticky_a: assert property ( // see (RL1)
      @(posedge clk) disable iff (!rst_b)
      flag_reg[i] && !(ce && clr_in[i]) |=> flag_reg[i])
      else $error("Flag dropped without a clear.");
  end

endmodule

`default_nettype wire

// ==== verilog/msr_meas_capture.sv ====
// Read-only measurement register loaded from the measurement path.
`timescale 1ns/1ns
`default_nettype none

module msr_meas_capture #(
  parameter int W = 16
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Measurement input
  input wire logic valid,
  input wire logic [W-1:0] value,
  // Register value
  output logic [W-1:0] reading
);

  logic [W-1:0] reading_reg;

  assign reading = reading_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reading_reg <= '0; // see (RL8)
    end else if (ce && valid) begin
      reading_reg <= value; // see (RL2) see (RL3) see (RL4) see (RL5)
    end
  end

  meas_load_a: assert property ( // see (RL2)
    @(posedge clk) disable iff (!rst_b)
    ce && valid |=> reading_reg == $past(value))
    else $error("Measurement was not loaded.");

  meas_hold_a: assert property ( // see (RL8)
    @(posedge clk) disable iff (!rst_b)
    !(ce && valid) |=> $stable(reading_reg))
    else $error("Measurement changed without a new value.");

endmodule

`default_nettype wire

// ==== tb/motor_status_readback_regs_test.sv ====
// Self-checking testbench of the motor status readback registers.
`timescale 1ns/1ns
`default_nettype none
`include "msr_defs.svh"

module motor_status_readback_regs_test;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [6:0] det = 7'h00;
  logic [3:0] mv = 4'h0;
  logic [15:0] md [4] = '{default: 16'h0000};
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ==========================================================================
  // Design
  // ==========================================================================
  msr_readback_regs u_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .closed_loop_stuck_det(det[5]), .open_loop_stuck_det(det[4]), .no_motor_det(det[3]),
    .emf_constant_abnormal_det(det[2]), .speed_abnormal_det(det[1]),
    .hw_current_limit_det(det[0]), .over_temperature_det(det[6]),
    .speed_valid(mv[0]), .speed_value(md[0]), .period_valid(mv[1]), .period_value(md[1]),
    .backemf_valid(mv[2]), .backemf_value(md[2]), .current_valid(mv[3]),
    .current_value(md[3][10:0]), .irq(irq)
  );

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      end_sim();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic end_sim();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0000_0000, n == 1}, 32'h0000_0001, "pready latency");
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string msg);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp, msg);
    chk({31'h0000_0000, er}, 32'h0000_0000, "pslverr on mapped read");
  endtask

  task automatic pulse(input logic [6:0] v);
    @(posedge clk);
    det <= v;
    @(posedge clk);
    det <= 7'h00;
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, irq}, {31'h0000_0000, exp}, "irq level");
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    logic [9:0] ix [6] = '{`MSR_IDX_FAULT, `MSR_IDX_SPEED, `MSR_IDX_PERIOD, `MSR_IDX_BEMF,
                           `MSR_IDX_CURRENT, `MSR_IDX_MASK};
    for (int i = 0; i < 6; i++) begin
      rd_chk(ix[i], 32'h0000_0000, "reset value");
    end
    chk({31'h0000_0000, irq}, 32'h0000_0000, "irq after reset");
  endtask

  task automatic t_meas();
    logic [9:0] ix [4] = '{`MSR_IDX_SPEED, `MSR_IDX_PERIOD, `MSR_IDX_BEMF, `MSR_IDX_CURRENT};
    logic [15:0] v [4] = '{16'ha5c3, 16'h5a3c, 16'hffff, 16'hffff};
    logic [15:0] e [4] = '{16'ha5c3, 16'h5a3c, 16'hffff, 16'h07ff};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      mv[i] <= 1'b1;
      md[i] <= v[i];
      @(posedge clk);
      mv[i] <= 1'b0;
      rd_chk(ix[i], {16'h0000, e[i]}, "measurement load");
      apb(1'b1, ix[i], 32'h0000_0000);
      chk({31'h0000_0000, er}, 32'h0000_0000, "read-only write error");
      rd_chk(ix[i], {16'h0000, e[i]}, "read-only write ignored");
    end
  endtask

  task automatic t_fault();
    int p;
    for (int k = 0; k < 7; k++) begin
      p = (k == 6) ? `MSR_BIT_OVER_TEMP : k;
      pulse(7'h01 << k);
      rd_chk(`MSR_IDX_FAULT, 32'h0000_0001 << p, "flag set");
      rd_chk(`MSR_IDX_FAULT, 32'h0000_0001 << p, "flag sticky");
      apb(1'b1, `MSR_IDX_FAULT, 32'h0000_0001 << p);
      rd_chk(`MSR_IDX_FAULT, 32'h0000_0000, "flag cleared");
    end
    pulse(7'h7f);
    apb(1'b1, `MSR_IDX_FAULT, 32'h0000_7fc0);
    rd_chk(`MSR_IDX_FAULT, 32'h0000_803f, "zero write keeps flags");
    apb(1'b1, `MSR_IDX_FAULT, 32'h0000_0021);
    rd_chk(`MSR_IDX_FAULT, 32'h0000_801e, "partial clear");
    apb(1'b1, `MSR_IDX_FAULT, 32'h0000_ffff);
    rd_chk(`MSR_IDX_FAULT, 32'h0000_0000, "full clear");
  endtask

  task automatic t_irq();
    apb(1'b1, `MSR_IDX_MASK, 32'h0000_ffff);
    rd_chk(`MSR_IDX_MASK, 32'h0000_803f, "mask writable bits");
    irq_chk(1'b0);
    pulse(7'h40);
    irq_chk(1'b1);
    apb(1'b1, `MSR_IDX_MASK, 32'h0000_0000);
    irq_chk(1'b0);
    apb(1'b1, `MSR_IDX_MASK, 32'h0000_8000);
    irq_chk(1'b1);
    apb(1'b1, `MSR_IDX_FAULT, 32'h0000_8000);
    irq_chk(1'b0);
  endtask

  task automatic t_ce();
    @(posedge clk);
    ce <= 1'b0;
    det <= 7'h01;
    mv[0] <= 1'b1;
    md[0] <= 16'h1234;
    @(posedge clk);
    ce <= 1'b1;
    det <= 7'h00;
    mv[0] <= 1'b0;
    rd_chk(`MSR_IDX_FAULT, 32'h0000_0000, "ce low blocks flag");
    rd_chk(`MSR_IDX_SPEED, 32'h0000_a5c3, "ce low blocks load");
  endtask

  task automatic t_unmapped();
    rd_chk(`MSR_IDX_SPEED, 32'h0000_a5c3, "speed before unmapped read");
    apb(1'b0, 10'h005, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001, "unmapped read error");
    chk(rd, 32'h0000_0000, "unmapped read data zero");
    apb(1'b1, 10'h3ff, 32'h0000_ffff);
    chk({31'h0000_0000, er}, 32'h0000_0001, "unmapped write error");
    rd_chk(`MSR_IDX_FAULT, 32'h0000_0000, "unmapped write no effect");
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_meas();
    t_fault();
    t_irq();
    t_ce();
    t_unmapped();
    end_sim();
  end
endmodule
`default_nettype wire
